// ---- inc/hcp_consts.svh ----
// timing and reset constants shared by both ends of the host port
`ifndef HCP_CONSTS_SVH
`define HCP_CONSTS_SVH
`define HCP_ADDR_W 12
`define HCP_DATA_W 16
`define HCP_NSTREAM 16
`define HCP_CLK_NS 8
`define HCP_RST_HOLD_NS 1000000
`define HCP_RST_HOLD_CYC ((`HCP_RST_HOLD_NS + `HCP_CLK_NS - 1) / `HCP_CLK_NS + 1)
`define HCP_STAB_NS 600000
`define HCP_STAB_CYC ((`HCP_STAB_NS + `HCP_CLK_NS - 1) / `HCP_CLK_NS)
`define HCP_REG_TOP 12'h0FF
`define HCP_CM_BASE 12'h400
`define HCP_DM_BASE 12'h800
`define HCP_REG_N 256
`define HCP_CM_N 1024
`define HCP_DM_N 1024
`endif

// ---- inc/hcp_pkg.sv ----
// types shared by both ends of the host port
package hcp_pkg;
  typedef enum logic [1:0] {HCP_REG, HCP_CMEM, HCP_DMEM} hcp_space_t;
  typedef enum {HCP_DV_IDLE, HCP_DV_ACK} hcp_dev_st_t;
  typedef enum {HCP_HS_RESET, HCP_HS_WAIT, HCP_HS_IDLE, HCP_HS_STRB,
                HCP_HS_REL} hcp_host_st_t;
endpackage

// ---- inc/hcp_if.sv ----
// pins between host and device: address, data, select, strobe, direction, ack
`timescale 1ns/1ps
interface hcp_if;
  logic [11:0] addr;
  logic rd_wr;
  logic sel_n;
  logic data_strobe_n;
  logic reset_n;
  logic [15:0] d_host_o;
  logic d_host_oe;
  logic [15:0] d_dev_o;
  logic d_dev_oe;
  logic [15:0] data;
  logic ack_o;
  logic ack_oe;
  logic transfer_ack_n;
  // resolved wire levels; pull-up keeps ack high when undriven
  assign data = d_dev_oe ? d_dev_o : (d_host_oe ? d_host_o : 16'hFFFF);
  assign transfer_ack_n = ack_oe ? ack_o : 1'b1;
  modport dev (input addr, rd_wr, sel_n, data_strobe_n, reset_n, data,
               output d_dev_o, d_dev_oe, ack_o, ack_oe);
  modport host (output addr, rd_wr, sel_n, data_strobe_n, reset_n, d_host_o, d_host_oe,
                input data, transfer_ack_n);
endinterface // hcp_if

// ---- logic/hcp_device.sv ----
// device end of the parallel host port with its memories and reset behaviour
`include "hcp_consts.svh"
`timescale 1ns/1ps
module hcp_device (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  // host pins
  hcp_if.dev port,
  // switch core side
  input wire logic [15:0] dm_wr_data,
  input wire logic [9:0] dm_wr_addr,
  input wire logic dm_wr_en,
  output logic [15:0] serial_out_en,
  output logic [15:0] hiz_control_outputs,
  output logic [15:0] ctrl_reg0,
  output logic [15:0] access_count
);
  import hcp_pkg::*;
  logic [15:0] regs_q [0:`HCP_REG_N-1];
  logic [15:0] cmem_q [0:`HCP_CM_N-1];
  logic [15:0] dmem_q [0:`HCP_DM_N-1];
  hcp_dev_st_t st_q, st_d;
  logic [15:0] rdata_q, rdata_d;
  logic drv_q, drv_d, ack_q, ack_d;
  logic [15:0] cnt_q, cnt_d;
  logic reg_we, cm_we, sel_act;
  logic in_rst;

  // address decode into the three spaces
  function automatic hcp_space_t space_of(input logic [11:0] a);
    if (a <= `HCP_REG_TOP) space_of = HCP_REG;
    else if (a < `HCP_DM_BASE) space_of = HCP_CMEM;
    else space_of = HCP_DMEM;
  endfunction

  // reset pin combines with system reset
  assign in_rst = ~port.reset_n;
  assign sel_act = ~port.sel_n & ~port.data_strobe_n;

  // access handshake: one access per strobe, ack held until strobe or select drops
  always_comb begin
    st_d = st_q;
    rdata_d = rdata_q;
    drv_d = drv_q;
    ack_d = ack_q;
    cnt_d = cnt_q;
    reg_we = 1'b0;
    cm_we = 1'b0;
    case (st_q)
      HCP_DV_IDLE: begin
        if (sel_act) begin
          st_d = HCP_DV_ACK;
          ack_d = 1'b1;
          cnt_d = cnt_q + 16'h0001;
          if (port.rd_wr) begin
            drv_d = 1'b1;
            case (space_of(port.addr))
              HCP_REG: rdata_d = regs_q[port.addr[7:0]];
              HCP_CMEM: rdata_d = cmem_q[port.addr[9:0]];
              default: rdata_d = dmem_q[port.addr[9:0]];
            endcase
          end else begin
            // data memory writes are dropped but still acknowledged
            reg_we = (space_of(port.addr) == HCP_REG);
            cm_we = (space_of(port.addr) == HCP_CMEM);
          end
        end
      end
      HCP_DV_ACK: begin
        if (port.sel_n | port.data_strobe_n) begin
          st_d = HCP_DV_IDLE;
          ack_d = 1'b0;
          drv_d = 1'b0;
        end
      end
      default: st_d = HCP_DV_IDLE;
    endcase
  end

  // handshake state; the reset pin clears it like system reset
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= HCP_DV_IDLE;
      rdata_q <= 16'h0000;
      drv_q <= 1'b0;
      ack_q <= 1'b0;
      cnt_q <= 16'h0000;
    end else if (clk_en) begin
      if (in_rst) begin
        st_q <= HCP_DV_IDLE;
        rdata_q <= 16'h0000;
        drv_q <= 1'b0;
        ack_q <= 1'b0;
        cnt_q <= 16'h0000;
      end else begin
        st_q <= st_d;
        rdata_q <= rdata_d;
        drv_q <= drv_d;
        ack_q <= ack_d;
        cnt_q <= cnt_d;
      end
    end
  end

  // register file only; registers cleared one word per cycle is too slow,
  // so registers clear at once and memories keep contents (treated as storage)
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < `HCP_REG_N; i++) regs_q[i] <= 16'h0000;
    end else if (clk_en) begin
      if (in_rst) begin
        for (int i = 0; i < `HCP_REG_N; i++) regs_q[i] <= 16'h0000;
      end else if (reg_we) begin
        regs_q[port.addr[7:0]] <= port.data;
      end
    end
  end

  // memories have no reset; a write from the host lands only in connection memory
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      if (cm_we & ~in_rst) cmem_q[port.addr[9:0]] <= port.data;
      if (dm_wr_en) dmem_q[dm_wr_addr] <= dm_wr_data;
    end
  end

  // serial output enables and hiz controls; held safe during reset
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      serial_out_en <= 16'h0000;
      hiz_control_outputs <= 16'hFFFF;
      ctrl_reg0 <= 16'h0000;
      access_count <= 16'h0000;
    end else if (clk_en) begin
      if (in_rst) begin
        serial_out_en <= 16'h0000;
        hiz_control_outputs <= 16'hFFFF;
      end else begin
        serial_out_en <= regs_q[1];
        hiz_control_outputs <= ~regs_q[1];
      end
      ctrl_reg0 <= regs_q[0];
      access_count <= cnt_q;
    end
  end

  // pin drivers straight from flops; the ack level is tied low
  assign port.d_dev_o = rdata_q;
  assign port.d_dev_oe = drv_q;
  assign port.ack_o = 1'b0;
  assign port.ack_oe = ack_q;
endmodule // hcp_device

// ---- logic/hcp_host.sv ----
// host end: drives reset pin, waits, then runs one access per request
`include "hcp_consts.svh"
`timescale 1ns/1ps
module hcp_host #(
  parameter int RST_HOLD_CYC = `HCP_RST_HOLD_CYC,
  parameter int STAB_CYC = `HCP_STAB_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  // device pins
  hcp_if.host port,
  // user request
  input wire logic req,
  input wire logic req_rd,
  input wire logic [11:0] req_addr,
  input wire logic [15:0] req_wdata,
  output logic ready,
  output logic done,
  output logic [15:0] rdata
);
  import hcp_pkg::*;
  hcp_host_st_t st_q, st_d;
  logic [31:0] cnt_q, cnt_d;
  logic [11:0] addr_q, addr_d;
  logic [15:0] wd_q, wd_d, rd_q, rd_d;
  logic rw_q, rw_d, done_d, rdy_d, done_q, rdy_q;

  // sequencer: reset hold, stabilise wait, then strobe/ack handshakes
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    wd_d = wd_q;
    rd_d = rd_q;
    rw_d = rw_q;
    done_d = 1'b0;
    rdy_d = 1'b0;
    case (st_q)
      HCP_HS_RESET: begin
        cnt_d = cnt_q + 32'h0000_0001;
        if (cnt_q >= 32'(RST_HOLD_CYC)) begin
          st_d = HCP_HS_WAIT;
          cnt_d = 32'h0000_0000;
        end
      end
      HCP_HS_WAIT: begin
        cnt_d = cnt_q + 32'h0000_0001;
        if (cnt_q >= 32'(STAB_CYC)) begin
          st_d = HCP_HS_IDLE;
          rdy_d = 1'b1;
        end
      end
      HCP_HS_IDLE: begin
        rdy_d = 1'b1;
        if (req) begin
          st_d = HCP_HS_STRB;
          addr_d = req_addr;
          wd_d = req_wdata;
          rw_d = req_rd;
          rdy_d = 1'b0;
        end
      end
      HCP_HS_STRB: begin
        if (~port.transfer_ack_n) begin
          if (rw_q) rd_d = port.data;
          st_d = HCP_HS_REL;
        end
      end
      HCP_HS_REL: begin
        if (port.transfer_ack_n) begin
          st_d = HCP_HS_IDLE;
          done_d = 1'b1;
          rdy_d = 1'b1;
        end
      end
      default: st_d = HCP_HS_RESET;
    endcase
  end

  // registers only
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= HCP_HS_RESET;
      cnt_q <= 32'h0000_0000;
      addr_q <= 12'h000;
      wd_q <= 16'h0000;
      rd_q <= 16'h0000;
      rw_q <= 1'b1;
      done_q <= 1'b0;
      rdy_q <= 1'b0;
    end else if (clk_en) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      wd_q <= wd_d;
      rd_q <= rd_d;
      rw_q <= rw_d;
      done_q <= done_d;
      rdy_q <= rdy_d;
    end
  end

  // pins: select and strobe together, direction steady through the access
  assign port.reset_n = (st_q != HCP_HS_RESET);
  assign port.sel_n = (st_q != HCP_HS_STRB);
  assign port.data_strobe_n = (st_q != HCP_HS_STRB);
  assign port.rd_wr = rw_q;
  assign port.addr = addr_q;
  assign port.d_host_o = wd_q;
  assign port.d_host_oe = (st_q == HCP_HS_STRB) & ~rw_q;
  assign ready = rdy_q;
  assign done = done_q;
  assign rdata = rd_q;
endmodule // hcp_host

// ---- dv/hcp_monitor.sv ----
// checker on the pins between host end and device end
`timescale 1ns/1ps
module hcp_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // port pins
  input wire logic [11:0] addr,
  input wire logic rd_wr,
  input wire logic sel_n,
  input wire logic data_strobe_n,
  input wire logic reset_n,
  input wire logic d_host_oe,
  input wire logic d_dev_oe,
  input wire logic ack_o,
  input wire logic ack_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ack is only ever an answer to a selected strobe
  ack_cause_a:
    assert property (ack_oe |-> !$past(sel_n) && !$past(data_strobe_n)) else $error("stray ack");
  ack_low_a:
    assert property (ack_oe |-> !ack_o) else $error("ack driven high");
  ack_answer_a:
    assert property (!sel_n && !data_strobe_n && !ack_oe |=> ack_oe) else $error("no ack");
  ack_hold_a:
    assert property (ack_oe && !sel_n && !data_strobe_n |=> ack_oe) else $error("ack dropped");
  ack_release_a:
    assert property (ack_oe && (sel_n || data_strobe_n) |=> !ack_oe) else $error("ack held");
  dev_drive_a:
    assert property (d_dev_oe |-> ack_oe && rd_wr) else $error("device drives on write");
  read_drive_a:
    assert property (ack_oe && rd_wr |-> d_dev_oe) else $error("read not driven");
  no_fight_a:
    assert property (!(d_dev_oe && d_host_oe)) else $error("bus contention");
  dir_steady_a:
    assert property (!sel_n && !$past(sel_n) |-> $stable(rd_wr) && $stable(addr))
      else $error("direction or address moved");
  settle_wait_a:
    assert property ($rose(reset_n) |-> sel_n [*4]) else $error("access too soon");
  // main scenarios
  cov_rd: cover property (ack_oe && rd_wr);
  cov_wr: cover property (ack_oe && !rd_wr);
  cov_rst: cover property ($rose(reset_n));
endmodule // hcp_monitor

// ---- dv/tb_host_cpu_port_and_reset.sv ----
// self-checking bench: host end and device end joined over the port
`timescale 1ns/1ps
module tb_host_cpu_port_and_reset;
  import hcp_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic req = 1'b0;
  logic req_rd = 1'b0;
  logic [11:0] req_addr = 12'h000;
  logic [15:0] req_wdata = 16'h0000;
  logic [15:0] dm_wr_data = 16'h0000;
  logic [9:0] dm_wr_addr = 10'h000;
  logic dm_wr_en = 1'b0;
  logic ready, done;
  logic [15:0] rdata, serial_out_en, hiz_control_outputs, ctrl_reg0, access_count;
  int n_mismatch = 0;
  int tests_run = 0;
  int n_acc = 0;
  logic [15:0] v, w;
  logic [9:0] a;
  hcp_if bus ();
  // short reset and settle counts keep the run brief
  hcp_host #(.RST_HOLD_CYC(4), .STAB_CYC(4)) i_hcp_host (.clk_sys, .sys_rst,
    .clk_en(1'b1), .port(bus), .req, .req_rd, .req_addr, .req_wdata, .ready, .done, .rdata);
  hcp_device i_hcp_device (.clk_sys, .sys_rst, .clk_en(1'b1), .port(bus), .dm_wr_data,
    .dm_wr_addr, .dm_wr_en, .serial_out_en, .hiz_control_outputs, .ctrl_reg0, .access_count);
  hcp_monitor i_hcp_monitor (.clk_sys, .sys_rst, .addr(bus.addr), .rd_wr(bus.rd_wr),
    .sel_n(bus.sel_n), .data_strobe_n(bus.data_strobe_n), .reset_n(bus.reset_n),
    .d_host_oe(bus.d_host_oe), .d_dev_oe(bus.d_dev_oe), .ack_o(bus.ack_o), .ack_oe(bus.ack_oe));
  // free running clock
  always #4 clk_sys = ~clk_sys;
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // hiz controls are the inverse of the serial output enables
  function automatic logic [15:0] hiz_exp(input logic [15:0] en);
    return ~en;
  endfunction
  // data memory is read-only from the host, so a read returns what the core wrote
  function automatic logic [15:0] rd_exp(input logic [11:0] ad, input logic [15:0] wr,
                                         input logic [15:0] core);
    return (ad >= 12'h800) ? core : wr;
  endfunction
  // inputs only change 1 ns after an edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // one access through the user side; waits are bounded
  task automatic acc(input logic rd, input logic [11:0] ad, input logic [15:0] wd);
    int k;
    for (k = 0; k < 99 && ready !== 1'b1; k++) tick(1);
    req = 1'b1;
    req_rd = rd;
    req_addr = ad;
    req_wdata = wd;
    tick(1);
    req = 1'b0;
    for (k = 0; k < 20 && done !== 1'b1; k++) tick(1);
    n_acc++;
    chk("done", {15'h0000, done}, 16'h0001);
  endtask
  task automatic rdchk(input string nm, input logic [11:0] ad, input logic [15:0] exp);
    acc(1'b1, ad, 16'h0000);
    chk(nm, rdata, exp);
  endtask
  // reset, then look at the silenced outputs while the pin is still low
  task automatic do_rst(input int n);
    int k;
    sys_rst = 1'b1;
    tick(n);
    sys_rst = 1'b0;
    n_acc = 0;
    tick(1);
    chk("hiz", hiz_control_outputs, 16'hFFFF);
    chk("soe", serial_out_en, 16'h0000);
    chk("reg0", ctrl_reg0, 16'h0000);
    chk("cnt", access_count, 16'h0000);
    for (k = 0; k < 99 && bus.reset_n !== 1'b1; k++) tick(1);
    chk("rst_len", {15'h0000, k >= 3}, 16'h0001);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    void'($urandom(58062));
    do_rst(16);
    $display("test reset done");
    v = 16'($urandom());
    acc(1'b0, 12'h001, v);
    chk("soe", serial_out_en, v);
    chk("hiz", hiz_control_outputs, hiz_exp(v));
    rdchk("reg1", 12'h001, v);
    $display("test enables done");
    // back-to-back accesses over all three spaces
    repeat (8) begin
      v = 16'($urandom());
      w = 16'($urandom());
      a = 10'($urandom());
      acc(1'b0, 12'h000, v);
      acc(1'b0, {2'b01, a}, w);
      chk("reg0", ctrl_reg0, v);
      rdchk("reg0_rd", 12'h000, v);
      rdchk("cmem", {2'b01, a}, rd_exp({2'b01, a}, w, ~w));
      dm_wr_addr = a;
      dm_wr_data = ~w;
      dm_wr_en = 1'b1;
      tick(1);
      dm_wr_en = 1'b0;
      acc(1'b0, {2'b10, a}, w);
      rdchk("dmem", {2'b10, a}, rd_exp({2'b10, a}, w, ~w));
    end
    chk("count", access_count, 16'(n_acc));
    $display("test spaces done");
    // a second reset clears registers but not memory contents
    do_rst(2);
    rdchk("reg0_clr", 12'h000, 16'h0000);
    rdchk("cmem_keep", {2'b01, a}, w);
    $display("test mid reset done");
    give_verdict();
  end
  // watchdog: whole run needs a few hundred cycles
  initial begin
    #200000;
    n_mismatch++;
    give_verdict();
  end
endmodule // tb_host_cpu_port_and_reset
